// ==== core/uemls_map.svh ====
// Register map, field positions, reset values and timing figures of the error/LED block.
`ifndef UEMLS_MAP_SVH
`define UEMLS_MAP_SVH

// Register byte offsets on the APB slave.
`define UEMLS_OFF_LAST_FAULT 8'h00
`define UEMLS_OFF_FAULT_POP  8'h04
`define UEMLS_OFF_IRQ_STS    8'h08
`define UEMLS_OFF_IRQ_MASK   8'h0C
`define UEMLS_OFF_LED_STATE  8'h10

// Error codes held in the error memory.
`define UEMLS_CODE_NONE      2'h0
`define UEMLS_CODE_OVTRIG    2'h1
`define UEMLS_CODE_USERSET   2'h2
`define UEMLS_CODE_PARAM     2'h3

// Error memory depth: one slot per error type.
`define UEMLS_DEPTH          3

// Interrupt status bit positions.
`define UEMLS_IRQ_OVTRIG     0
`define UEMLS_IRQ_USERSET    1
`define UEMLS_IRQ_PARAM      2
`define UEMLS_IRQ_INTERR     3
`define UEMLS_IRQ_W          4

// Field positions of the LED state register.
`define UEMLS_LED_MODE_LSB   0
`define UEMLS_LED_CNT_LSB    4

// Reset value of all state, and the write value that pops the error memory.
`define UEMLS_ST_RST         '0
`define UEMLS_POP_CMD        32'h0000_0001

// Flash half period, in milliseconds, and its cycle count at 125 MHz.
`define UEMLS_CLK_KHZ        125000
`define UEMLS_FLASH_MS       250
`define UEMLS_FLASH_CYC      (`UEMLS_FLASH_MS * `UEMLS_CLK_KHZ)

`endif

// ==== core/uemls_pkg.sv ====
// Types shared by the error memory and LED status modules.
`default_nettype none
`include "uemls_map.svh"

package uemls_pkg;

   // LED display modes, lowest encoding first.
   typedef enum logic [2:0] {
      UEMLS_LED_BOOT,
      UEMLS_LED_OK,
      UEMLS_LED_WAIT,
      UEMLS_LED_USER,
      UEMLS_LED_INTERNAL
   } uemls_led_mode_t;

   // State of the flash divider.
   typedef struct packed {
      logic [31:0] cnt;   // Cycles since the last pulse.
      logic        en;    // One-cycle enable pulse.
   } uemls_tick_st_t;

   // State of the error memory.
   typedef struct packed {
      logic [`UEMLS_DEPTH-1:0][1:0] ent;  // Stored codes, oldest at index 0.
      logic [1:0]                   cnt;  // Number of stored codes.
   } uemls_estack_st_t;

   // State of the top level.
   typedef struct packed {
      logic [31:0]           prdata;    // Read data prepared in the setup cycle.
      logic [`UEMLS_IRQ_W-1:0] sts;     // Sticky interrupt status.
      logic [`UEMLS_IRQ_W-1:0] mask;    // Interrupt enables.
      logic                  irq;       // Registered interrupt level.
      logic                  red;       // Red LED element.
      logic                  green;     // Green LED element.
      logic                  phase;     // Flash phase.
      uemls_led_mode_t       mode;      // Current LED mode.
      logic                  int_prev;  // Internal error, one cycle late.
   } uemls_top_st_t;

endpackage : uemls_pkg
`default_nettype wire

// ==== core/uemls_tick.sv ====
// Free-running divider that gives a one-cycle enable every PERIOD cycles.
`timescale 1ns/1ps
`default_nettype none
`include "uemls_map.svh"

module uemls_tick #(
   parameter int unsigned PERIOD = 2
) (
   input  wire logic pclk,
   input  wire logic presetn,
   output logic      en
);

   uemls_pkg::uemls_tick_st_t s_q;  // Registered state.
   uemls_pkg::uemls_tick_st_t s_d;  // Next state.

   // Count up and wrap; the pulse comes from a flop so it is glitch free.
   always_comb begin
      s_d    = s_q;
      s_d.en = 1'b0;
      if (s_q.cnt >= 32'(PERIOD - 1)) begin
         s_d.cnt = 32'h0000_0000;
         s_d.en  = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 32'h0000_0001;
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= `UEMLS_ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign en = s_q.en;

endmodule : uemls_tick
`default_nettype wire

// ==== core/uemls_estack.sv ====
// Error memory: a stack holding each error code at most once.
`timescale 1ns/1ps
`default_nettype none
`include "uemls_map.svh"

module uemls_estack (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic [`UEMLS_DEPTH-1:0] push,
   input  wire logic                   pop,
   output logic      [1:0]             top_code,
   output logic      [1:0]             count
);

   uemls_pkg::uemls_estack_st_t s_q;  // Registered state.
   uemls_pkg::uemls_estack_st_t s_d;  // Next state.

   // Pop first, then push each detected code not yet held, so a detection
   // in the pop cycle is never lost, even of the code being popped.
   always_comb begin
      logic hit;
      hit = 1'b0;
      s_d = s_q;
      if (pop && s_q.cnt != 2'h0) begin
         s_d.cnt = s_q.cnt - 2'h1;
      end
      for (int i = 0; i < `UEMLS_DEPTH; i++) begin
         hit = 1'b0;
         for (int j = 0; j < `UEMLS_DEPTH; j++) begin
            if (2'(j) < s_d.cnt && s_d.ent[j] == 2'(i + 1)) begin
               hit = 1'b1;
            end
         end
         // One slot per type, so the stack can never overflow.
         if (push[i] && !hit) begin
            s_d.ent[s_d.cnt] = 2'(i + 1);
            s_d.cnt          = s_d.cnt + 2'h1;
         end
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= `UEMLS_ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Newest code, or no-error while empty.
   assign top_code = (s_q.cnt == 2'h0) ? `UEMLS_CODE_NONE
                                       : s_q.ent[s_q.cnt - 2'h1];
   assign count    = s_q.cnt;

endmodule : uemls_estack
`default_nettype wire

// ==== core/uemls_top.sv ====
// User error memory with APB registers, interrupt and two-colour status LED.
`timescale 1ns/1ps
`default_nettype none
`include "uemls_map.svh"

module uemls_top #(
   parameter int unsigned FLASH_CYC = `UEMLS_FLASH_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        acq_trig,
   input  wire logic        acq_wait,
   input  wire logic        frame_trig,
   input  wire logic        frame_wait,
   input  wire logic        userset_fail,
   input  wire logic        param_invalid,
   input  wire logic        boot_done,
   input  wire logic        internal_err,
   input  wire logic        trig_expected,
   input  wire logic        trig_present,
   output logic             led_red,
   output logic             led_green,
   output logic             irq
);

   // All state of the top level lives in one packed struct.
   // One combinational process works out the next copy of it.
   // One clocked process registers that copy on every edge.
   // This keeps prdata, irq and the LED outputs on flops and gives one reset point.
   // The price is that each of those is one cycle behind its cause; pslverr is combinational.
   // For a lamp and a polled register bank that delay is harmless.
   // The error memory and the divider keep their own state.
   // Only their outputs are seen here.
   uemls_pkg::uemls_top_st_t s_q;  // Registered state.
   uemls_pkg::uemls_top_st_t s_d;  // Next state.

   logic                      flash_en;   // Flash phase toggle enable.
   logic [`UEMLS_DEPTH-1:0]   push;       // Detected codes, one bit per type.
   logic                      pop;        // Pop command from software.
   logic [1:0]                top_code;   // Newest stored code.
   logic [1:0]                count;      // Codes held.
   logic                      setup;      // APB setup cycle.
   logic                      access;     // APB access cycle.
   logic                      mapped;     // Address hits a register.
   logic                      wr;         // Write takes effect now.
   logic [`UEMLS_IRQ_W-1:0]   ev;         // Interrupt events this cycle.
   logic                      ovtrig;     // Overtrigger detected.

   // The divider gives one enable pulse per flash half period.
   // It runs freely, so every flashing mode shares one phase.
   // A mode change therefore does not restart the flash cycle.
   // That keeps the logic small at the cost of a short first flash.
   // Divider for the flash rate; the count is long, so it is a parameter.
   uemls_tick #(
      .PERIOD (FLASH_CYC)
   ) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .en      (flash_en)
   );

   // The memory stores each error type at most once.
   // Its depth equals the number of types, so it never overflows.
   // It reports the newest code and the number of codes held.
   // Pushes and the pop arrive in the same cycle without conflict.
   // The error memory itself.
   uemls_estack u_estack (
      .pclk     (pclk),
      .presetn  (presetn),
      .push     (push),
      .pop      (pop),
      .top_code (top_code),
      .count    (count)
   );

   // Both trigger kinds share the same error code.
   // The wait levels come from the acquisition control logic.
   // A trigger that finds its wait level high is a normal trigger.
   // Only triggers that arrive too early are recorded here.
   // A trigger is an overtrigger when the matching wait state is absent.
   assign ovtrig = (acq_trig && !acq_wait)
                || (frame_trig && !frame_wait);

   // The push vector has one bit per error type.
   // Code zero means no error and so has no bit of its own.
   // A pulse held for several cycles is harmless, since repeats merge.
   // Bit i of push stands for code i+1.
   assign push[`UEMLS_CODE_OVTRIG - 2'h1]  = ovtrig;
   assign push[`UEMLS_CODE_USERSET - 2'h1] = userset_fail;
   assign push[`UEMLS_CODE_PARAM - 2'h1]   = param_invalid;

   // The setup cycle prepares read data; the access cycle commits writes.
   // The decode only says whether an address hits a register.
   // Each register is one aligned word at its own byte offset.
   // Byte lanes are not used, so a write always covers the word.
   // Partial addresses inside a word are treated as unmapped.
   // APB phase and address decode.
   assign setup  = psel && !penable;
   assign access = psel && penable;
   always_comb begin
      case (paddr)
         `UEMLS_OFF_LAST_FAULT,
         `UEMLS_OFF_FAULT_POP,
         `UEMLS_OFF_IRQ_STS,
         `UEMLS_OFF_IRQ_MASK,
         `UEMLS_OFF_LED_STATE: begin
            mapped = 1'b1;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // Every register answers at once, so no wait logic is needed.
   // Software may issue transfers back to back.
   // An error response leaves every register untouched.
   // Zero wait states: every access ends in its first access cycle.
   assign pready  = 1'b1;
   // Unmapped addresses answer with an error and have no effect.
   assign pslverr = access && !mapped;
   assign wr      = access && pwrite && mapped;

   // The pop register holds no state; a write is a command.
   // Requiring the exact value guards against a stray write.
   // A pop on an empty memory has no effect there.
   // Only a write of exactly one pops; any other value is ignored.
   assign pop = wr && paddr == `UEMLS_OFF_FAULT_POP
                   && pwdata == `UEMLS_POP_CMD;

   // Every detection raises its status bit, even a repeated one.
   // The internal error is a level, so only its onset is an event.
   // Otherwise software could never clear that bit while it lasts.
   // A second onset needs the level to fall and rise again.
   // Interrupt events: each detection, and the onset of an internal error.
   always_comb begin
      ev                          = '0;
      ev[`UEMLS_IRQ_OVTRIG]       = ovtrig;
      ev[`UEMLS_IRQ_USERSET]      = userset_fail;
      ev[`UEMLS_IRQ_PARAM]        = param_invalid;
      ev[`UEMLS_IRQ_INTERR]       = internal_err && !s_q.int_prev;
   end

   // The process starts from a copy of the present state.
   // Each part below changes only the fields that it owns.
   // Fields that nothing touches in a cycle simply hold.
   // The LED decode reads the mode chosen in this same pass.
   // Mode and colours therefore change on the same edge.
   // Next-state logic: registers, read data, interrupt and LED.
   always_comb begin
      s_d          = s_q;
      s_d.int_prev = internal_err;

      // Read data is prepared in the setup cycle so it comes from a flop;
      // the price is that a code stored during the setup cycle itself is
      // seen only by the next read.
      if (setup) begin
         s_d.prdata = 32'h0000_0000;
         case (paddr)
            `UEMLS_OFF_LAST_FAULT: begin
               s_d.prdata[1:0] = top_code;
            end
            `UEMLS_OFF_IRQ_STS: begin
               s_d.prdata[`UEMLS_IRQ_W-1:0] = s_q.sts;
            end
            `UEMLS_OFF_IRQ_MASK: begin
               s_d.prdata[`UEMLS_IRQ_W-1:0] = s_q.mask;
            end
            `UEMLS_OFF_LED_STATE: begin
               s_d.prdata[`UEMLS_LED_MODE_LSB +: 3] = s_q.mode;
               s_d.prdata[`UEMLS_LED_CNT_LSB +: 2]  = count;
            end
            default: begin
               // Pop register and unmapped addresses read as zero.
               s_d.prdata = 32'h0000_0000;
            end
         endcase
      end

      // Bits that software writes as zero keep their value.
      // The clear and a new event may land in the same cycle.
      // Letting the event win means no event can be lost.
      // Sticky status: write one to clear, and a new event wins the clear.
      s_d.sts = s_q.sts;
      if (wr && paddr == `UEMLS_OFF_IRQ_STS) begin
         s_d.sts = s_q.sts & ~pwdata[`UEMLS_IRQ_W-1:0];
      end
      s_d.sts = s_d.sts | ev;

      // Mask register.
      if (wr && paddr == `UEMLS_OFF_IRQ_MASK) begin
         s_d.mask = pwdata[`UEMLS_IRQ_W-1:0];
      end

      // Level interrupt while any unmasked status bit is set.
      s_d.irq = |(s_d.sts & s_d.mask);

      // Flash phase toggles at the divider rate in every flashing mode.
      if (flash_en) begin
         s_d.phase = !s_q.phase;
      end

      // The conditions are tested in order of priority.
      // An internal error hides any user error still held.
      // User errors hide a missing trigger.
      // A healthy device with nothing pending shows solid green.
      // The count is registered, so the lamp follows a new code
      // one cycle after the code is stored.
      // Mode selection; boot overrides everything until it completes.
      if (!boot_done) begin
         s_d.mode = uemls_pkg::UEMLS_LED_BOOT;
      end else if (internal_err) begin
         s_d.mode = uemls_pkg::UEMLS_LED_INTERNAL;
      end else if (count != 2'h0) begin
         s_d.mode = uemls_pkg::UEMLS_LED_USER;
      end else if (trig_expected && !trig_present) begin
         s_d.mode = uemls_pkg::UEMLS_LED_WAIT;
      end else begin
         s_d.mode = uemls_pkg::UEMLS_LED_OK;
      end

      // LED drive follows the mode chosen in this cycle.
      case (s_d.mode)
         uemls_pkg::UEMLS_LED_BOOT: begin
            s_d.red   = 1'b1;
            s_d.green = 1'b1;
         end
         uemls_pkg::UEMLS_LED_INTERNAL: begin
            s_d.red   = s_d.phase;
            s_d.green = 1'b0;
         end
         uemls_pkg::UEMLS_LED_USER: begin
            s_d.red   = s_d.phase;
            s_d.green = !s_d.phase;
         end
         uemls_pkg::UEMLS_LED_WAIT: begin
            s_d.red   = 1'b0;
            s_d.green = s_d.phase;
         end
         uemls_pkg::UEMLS_LED_OK: begin
            s_d.red   = 1'b0;
            s_d.green = 1'b1;
         end
         default: begin
            // Unused encodings show boot colours rather than going dark.
            s_d.red   = 1'b1;
            s_d.green = 1'b1;
         end
      endcase
   end

   // The reset branch loads constants only.
   // The first edge after reset shows the boot colours.
   // State register; everything clears, so the LED is dark during reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= `UEMLS_ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops.
   assign prdata    = s_q.prdata;
   assign led_red   = s_q.red;
   assign led_green = s_q.green;
   assign irq       = s_q.irq;

endmodule : uemls_top
`default_nettype wire

// ==== testbench/uemls_led_model.sv ====
// Two-colour status lamp model that counts every colour change seen.
`timescale 1ns/1ps
`default_nettype none

module uemls_led_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        red,
   input  wire logic        green,
   output logic      [15:0] flips
);
   logic [1:0] last_q;  // Colour shown one cycle ago.

   // A lamp obeys no protocol; an observer only sees its colour change.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= 2'b00;
         flips  <= 16'h0000;
      end else begin
         last_q <= {red, green};
         if ({red, green} != last_q) flips <= flips + 16'h0001;
      end
   end
endmodule : uemls_led_model
`default_nettype wire

// ==== testbench/uemls_top_asserts.sv ====
// Port-level assertions for the error memory and status lamp block.
`timescale 1ns/1ps
`default_nettype none

module uemls_top_asserts #(
   parameter int unsigned FLASH_CYC = 8
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        boot_done,
   input wire logic        internal_err,
   input wire logic        led_red,
   input wire logic        led_green
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic mapped;  // Address hits one of the five registers.
   assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};

   a_ready_high: assert property (pready)
      else $error("pready low");
   a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
      else $error("no error on unmapped access");
   a_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
      else $error("error on mapped access");
   a_err_idle: assert property (!(psel && penable) |-> !pslverr)
      else $error("error outside access");
   a_rdata_zero: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (psel && penable |=> $stable(prdata))
      else $error("read data moved after access");
   a_boot_both: assert property (!boot_done [*3] |-> led_red && led_green)
      else $error("both lamps not lit during boot");
   a_int_green: assert property ((boot_done && internal_err) [*3] |-> !led_green)
      else $error("green lit on internal error");
   a_boot_excl: assert property (boot_done [*3] |-> !(led_red && led_green))
      else $error("both lamps lit after boot");
endmodule : uemls_top_asserts
`default_nettype wire

// ==== testbench/uemls_top_bench.sv ====
// Self-checking bench for the error memory and status lamp block.
`timescale 1ns/1ps
`default_nettype none
`include "uemls_map.svh"
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin miscompares++; \
   $display("[FAIL] %0t got %h want %h", $time, act, exp); end end

module uemls_top_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  evt;  // Pulses: param, userset, frame, acquisition.
   logic        acq_wait, frame_wait, boot_done, internal_err;
   logic        trig_expected, trig_present, led_red, led_green, irq;
   logic [15:0] flips;
   logic [32:0] exp_q[$];  // Expected {pslverr, prdata} of pending reads.
   logic [32:0] e_now;
   int          miscompares, total_checks, seed;

   uemls_top #(.FLASH_CYC(8)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .acq_trig(evt[0]), .acq_wait(acq_wait), .frame_trig(evt[1]), .frame_wait(frame_wait),
      .userset_fail(evt[2]), .param_invalid(evt[3]), .boot_done(boot_done),
      .internal_err(internal_err), .trig_expected(trig_expected),
      .trig_present(trig_present), .led_red(led_red), .led_green(led_green), .irq(irq));

   uemls_led_model i_led (
      .pclk(pclk), .presetn(presetn), .red(led_red), .green(led_green), .flips(flips));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // Reads are judged at their access edge, oldest note first.
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
         e_now = exp_q.pop_front();
         `CHK({pslverr, prdata}, e_now)
      end
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      if (!w) exp_q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask : wr

   // Holds the given event pulses high for n cycles.
   task automatic ev(input logic [3:0] v, input int n);
      @(posedge pclk);
      evt <= v;
      repeat (n) @(posedge pclk);
      evt <= 4'h0;
      repeat (2) @(posedge pclk);
   endtask : ev

   // Watches the lamp: 0 solid green, 1 green flash, 2 alternate, 3 red flash, 4 boot.
   task automatic led_watch(input int m);
      logic [15:0] f0;
      repeat (3) @(posedge pclk);
      f0 = flips;
      repeat (24) begin
         @(posedge pclk);
         case (m)
            0: `CHK({led_red, led_green}, 2'b01)
            1: `CHK(led_red, 1'b0)
            2: `CHK(led_red ^ led_green, 1'b1)
            3: `CHK(led_green, 1'b0)
            default: `CHK({led_red, led_green}, 2'b11)
         endcase
      end
      `CHK(flips != f0, m inside {1, 2, 3})
   endtask : led_watch

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      end_of_test();
   end

   initial begin
      seed = 32'h65468E63;
      {psel, penable, pwrite, paddr, pwdata, evt} = '0;
      {acq_wait, frame_wait, boot_done, internal_err} = 4'b1100;
      {trig_expected, trig_present} = 2'b01;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      led_watch(4);
      rd(8'h00, 32'h0);
      rd(8'h0C, 32'h0);
      boot_done <= 1'b1;
      led_watch(0);
      wr(8'h04, 32'h1);
      rd(8'h00, 32'h0);
      wr(8'h0C, 32'hF);
      rd(8'h0C, 32'hF);
      ev(4'h1, 1);
      rd(8'h00, 32'h0);
      acq_wait <= 1'b0;
      ev(4'h1, 1);
      acq_wait <= 1'b1;
      rd(8'h00, 32'h1);
      wr(8'h04, 32'h1);
      rd(8'h00, 32'h0);
      frame_wait <= 1'b0;
      ev(4'h2, 1);
      frame_wait <= 1'b1;
      rd(8'h00, 32'h1);
      ev(4'h8, 1 + ($random(seed) & 3));
      rd(8'h00, 32'h3);
      ev(4'h4, 1);
      rd(8'h00, 32'h2);
      ev(4'h8, 2);
      rd(8'h00, 32'h2);
      rd(8'h10, 32'h33);
      `CHK(irq, 1'b1)
      rd(8'h08, 32'h7);
      wr(8'h08, 32'h7);
      rd(8'h08, 32'h0);
      `CHK(irq, 1'b0)
      led_watch(2);
      internal_err <= 1'b1;
      led_watch(3);
      internal_err <= 1'b0;
      wr(8'h04, 32'h2);
      rd(8'h00, 32'h2);
      wr(8'h04, 32'h1);
      rd(8'h00, 32'h3);
      wr(8'h04, 32'h1);
      rd(8'h00, 32'h1);
      wr(8'h04, 32'h1);
      rd(8'h00, 32'h0);
      trig_expected <= 1'b1;
      trig_present <= 1'b0;
      led_watch(1);
      wr(8'h14, $random(seed));
      apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
      repeat (2) @(posedge pclk);
      end_of_test();
   end
endmodule : uemls_top_bench

bind uemls_top uemls_top_asserts #(.FLASH_CYC(FLASH_CYC)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .boot_done(boot_done), .internal_err(internal_err), .led_red(led_red),
   .led_green(led_green));
`default_nettype wire
